// [include/wwdt_pkg.sv]
// Package of constants and types for the window watchdog
package wwdt_pkg;
    localparam int CNT_W  = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int PRE_W  = 14;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_RELOAD = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_WINDOW = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;

    // Field positions
    localparam int CTRL_WAKEUP_BIT = 0;
    localparam int CTRL_LONG_BIT   = 1;
    localparam int STAT_EN_BIT     = 16;
    localparam int STAT_REQ_BIT    = 17;
    localparam int STAT_WIN_BIT    = 18;

    // Reset values: wake-up clock, divide by 16384, four ticks to overflow
    localparam logic [CNT_W-1:0] RELOAD_RST      = 16'hfffc;
    localparam logic [CNT_W-1:0] WINDOW_RST      = 16'h0000;
    localparam logic             CTRL_WAKEUP_RST = 1'b1;
    localparam logic             CTRL_LONG_RST   = 1'b1;
    localparam logic [CNT_W-1:0] CNT_ALL_ONES    = 16'hffff;

    // Prescaler ratios
    localparam int DIV_LONG  = 16384;
    localparam int DIV_SHORT = 256;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } wwdt_bus_t;

    typedef struct packed {
        logic presc_long;
        logic use_wakeup;
    } wwdt_ctrl_t;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_STOP = 2'b01,
        ST_TRIP = 2'b11
    } wwdt_state_t;
endpackage

// [src/wwdt_prescaler.sv]
// Selectable-ratio prescaler producing one-cycle count ticks
`timescale 1ns/1ps
`default_nettype none
module wwdt_prescaler import wwdt_pkg::*; #(
    parameter int W = PRE_W
) (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic src_tick_in,
    input  wire logic clear_in,
    input  wire logic long_in,
    output logic      tick_out
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_tick;
    logic [W-1:0] limit;

    // ---------------------------------------------------------------
    // Divider
    // ---------------------------------------------------------------
    always_comb begin
        limit     = long_in ? W'(DIV_LONG - 1) : W'(DIV_SHORT - 1);
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (clear_in) begin
            next_cnt = '0;
        end else if (src_tick_in) begin
            if (cnt >= limit) begin
                next_cnt  = '0;
                next_tick = 1'b1;
            end else begin
                next_cnt = W'(cnt + 1'b1);
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cnt      <= '0;
            tick_out <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            tick_out <= next_tick;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_quiet;
        !tick_out [*8];
    endsequence
    property p_tick_spacing;
        @(posedge clock_in) disable iff (rst_in)
        tick_out |=> s_quiet;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("Prescaler ticks too close");
endmodule
`default_nettype wire

// [src/wwdt_top.sv]
// Window watchdog timer with register port and instruction inputs
//
// Overview of operation
// - Every reset leaves the watchdog enabled and counting without software help.
// - Disable instruction stops counting, enable instruction restarts it, until the reset request is raised.
// - Missing service before overflow raises the reset request at overflow.
// - Service while running, with count below the window boundary and no disable in the same cycle, raises the reset request.
// - Counter is 16 bits, clocked from system clock or wake-up oscillator clock.
// - Selected clock is prescaled by 16384 or 256 before advancing the counter.
// - Each service that leaves the reset request low and comes without a disable loads the counter from the programmable reload value.
// - Defaults give about 0.13 s timeout with a 500 kHz wake-up clock.
`timescale 1ns/1ps
`default_nettype none
module wwdt_top import wwdt_pkg::*; (
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire wwdt_bus_t         bus_in,
    input  wire logic              wakeup_osc_clock_in,
    input  wire logic              watchdog_service_in,
    input  wire logic              watchdog_disable_instruction_in,
    input  wire logic              watchdog_enable_instruction_in,
    output logic [DATA_W-1:0]      rd_data_out,
    output logic                   reset_request_out,
    output logic                   running_out
);
    wwdt_ctrl_t          ctrl;
    wwdt_ctrl_t          next_ctrl;
    logic [CNT_W-1:0]    counter_reload_value;
    logic [CNT_W-1:0]    next_counter_reload_value;
    logic [CNT_W-1:0]    window;
    logic [CNT_W-1:0]    next_window;
    logic [DATA_W-1:0]   next_rd_data;
    logic [2:0]          wu_sync;
    logic [2:0]          next_wu_sync;
    logic                wu_level;
    logic                next_wu_level;
    logic                wu_tick;
    logic                src_tick;
    logic                cnt_tick;
    wwdt_state_t         state;
    wwdt_state_t         next_state;
    logic [CNT_W-1:0]    count;
    logic [CNT_W-1:0]    next_count;
    logic                win_fault;
    logic                next_win_fault;
    logic                service_ok;
    logic                service_bad;
    logic                do_disable;

    function automatic logic in_window(input logic [CNT_W-1:0] c,
                                       input logic [CNT_W-1:0] bound);
        in_window = (c < bound);
    endfunction

    // ---------------------------------------------------------------
    // Wake-up clock synchroniser
    // ---------------------------------------------------------------
    always_comb begin
        next_wu_sync  = {wu_sync[1:0], wakeup_osc_clock_in};
        next_wu_level = (wu_sync[1] == wu_sync[2]) ? wu_sync[2] : wu_level;
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wu_sync  <= 3'h0;
            wu_level <= 1'b0;
        end else begin
            wu_sync  <= next_wu_sync;
            wu_level <= next_wu_level;
        end
    end

    assign wu_tick  = wu_sync[1] & wu_sync[2] & ~wu_level;
    assign src_tick = (state == ST_RUN) && (ctrl.use_wakeup ? wu_tick : 1'b1);

    // ---------------------------------------------------------------
    // Prescaler
    // ---------------------------------------------------------------
    wwdt_prescaler #(
        .W (PRE_W)
    ) u_presc (
        .clock_in    (clock_in),
        .rst_in      (rst_in),
        .src_tick_in (src_tick),
        .clear_in    (service_ok),
        .long_in     (ctrl.presc_long),
        .tick_out    (cnt_tick)
    );

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    always_comb begin
        next_ctrl                 = ctrl;
        next_counter_reload_value = counter_reload_value;
        next_window               = window;
        next_rd_data              = '0;
        if (bus_in.wr) begin
            unique case (bus_in.addr)
                OFS_CTRL: begin
                    next_ctrl.use_wakeup = bus_in.wdata[CTRL_WAKEUP_BIT];
                    next_ctrl.presc_long = bus_in.wdata[CTRL_LONG_BIT];
                end
                OFS_RELOAD: next_counter_reload_value = bus_in.wdata[CNT_W-1:0];
                OFS_WINDOW: next_window = bus_in.wdata[CNT_W-1:0];
                default: ;
            endcase
        end
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                OFS_CTRL: begin
                    next_rd_data[CTRL_WAKEUP_BIT] = ctrl.use_wakeup;
                    next_rd_data[CTRL_LONG_BIT]   = ctrl.presc_long;
                end
                OFS_RELOAD: next_rd_data[CNT_W-1:0] = counter_reload_value;
                OFS_WINDOW: next_rd_data[CNT_W-1:0] = window;
                OFS_STATUS: begin
                    next_rd_data[CNT_W-1:0]    = count;
                    next_rd_data[STAT_EN_BIT]  = (state == ST_RUN);
                    next_rd_data[STAT_REQ_BIT] = reset_request_out;
                    next_rd_data[STAT_WIN_BIT] = win_fault;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ctrl.use_wakeup      <= CTRL_WAKEUP_RST;
            ctrl.presc_long      <= CTRL_LONG_RST;
            counter_reload_value <= RELOAD_RST;
            window               <= WINDOW_RST;
            rd_data_out          <= '0;
        end else begin
            ctrl                 <= next_ctrl;
            counter_reload_value <= next_counter_reload_value;
            window               <= next_window;
            rd_data_out          <= next_rd_data;
        end
    end

    // ---------------------------------------------------------------
    // Watchdog state and counter
    // ---------------------------------------------------------------
    assign do_disable  = watchdog_disable_instruction_in;
    assign service_bad = (state == ST_RUN) && !do_disable && watchdog_service_in
                         && in_window(count, window);
    assign service_ok  = watchdog_service_in && !service_bad && (state != ST_TRIP);

    always_comb begin
        next_state     = state;
        next_count     = count;
        next_win_fault = win_fault;
        unique case (state)
            ST_RUN: begin
                if (do_disable) begin
                    next_state = ST_STOP;
                end else if (service_bad) begin
                    next_state     = ST_TRIP;
                    next_win_fault = 1'b1;
                end else if (watchdog_service_in) begin
                    next_count = counter_reload_value;
                end else if (cnt_tick) begin
                    next_count = CNT_W'(count + 1'b1);
                    if (count == CNT_ALL_ONES) begin
                        next_state = ST_TRIP;
                    end
                end
            end
            ST_STOP: begin
                if (watchdog_enable_instruction_in && !do_disable) begin
                    next_state = ST_RUN;
                end
                if (watchdog_service_in) begin
                    next_count = counter_reload_value;
                end
            end
            ST_TRIP: next_state = ST_TRIP;
            default: next_state = ST_TRIP;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state             <= ST_RUN;
            count             <= RELOAD_RST;
            win_fault         <= 1'b0;
            reset_request_out <= 1'b0;
            running_out       <= 1'b1;
        end else begin
            state             <= next_state;
            count             <= next_count;
            win_fault         <= next_win_fault;
            reset_request_out <= (next_state == ST_TRIP);
            running_out       <= (next_state == ST_RUN);
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_out_of_reset;
        @(posedge clock_in) disable iff (rst_in)
        $past(rst_in) |-> (state == ST_RUN) && running_out && !reset_request_out;
    endproperty
    a_out_of_reset: assert property (p_out_of_reset) else $error("Not running after reset");

    property p_defaults;
        @(posedge clock_in) disable iff (rst_in)
        $past(rst_in) |-> (counter_reload_value == RELOAD_RST) && (window == WINDOW_RST)
                          && (ctrl.use_wakeup == CTRL_WAKEUP_RST)
                          && (ctrl.presc_long == CTRL_LONG_RST);
    endproperty
    a_defaults: assert property (p_defaults) else $error("Wrong default settings");

    property p_disable;
        @(posedge clock_in) disable iff (rst_in)
        (state == ST_RUN) && do_disable |=> (state == ST_STOP) && !running_out;
    endproperty
    a_disable: assert property (p_disable) else $error("Disable not taken");

    property p_enable;
        @(posedge clock_in) disable iff (rst_in)
        (state == ST_STOP) && watchdog_enable_instruction_in && !do_disable
        |=> (state == ST_RUN) && running_out;
    endproperty
    a_enable: assert property (p_enable) else $error("Enable not taken");

    property p_overflow;
        @(posedge clock_in) disable iff (rst_in)
        (state == ST_RUN) && !do_disable && !watchdog_service_in && cnt_tick
        && (count == CNT_ALL_ONES) |=> reset_request_out && (count == 16'h0000);
    endproperty
    a_overflow: assert property (p_overflow) else $error("Overflow without request");

    property p_window;
        @(posedge clock_in) disable iff (rst_in)
        (state == ST_RUN) && !do_disable && watchdog_service_in && (count < window)
        |=> reset_request_out && win_fault;
    endproperty
    a_window: assert property (p_window) else $error("Window refresh not caught");

    sequence s_legal_service;
        (state == ST_RUN) && !do_disable && watchdog_service_in && !(count < window);
    endsequence
    property p_reload;
        @(posedge clock_in) disable iff (rst_in)
        s_legal_service |=> (count == $past(counter_reload_value)) && !reset_request_out;
    endproperty
    a_reload: assert property (p_reload) else $error("Service did not reload");

    property p_step;
        @(posedge clock_in) disable iff (rst_in)
        (state == ST_RUN) && !do_disable && !watchdog_service_in && cnt_tick
        && (count != CNT_ALL_ONES) |=> count == $past(count) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("Counter did not step");

    property p_hold;
        @(posedge clock_in) disable iff (rst_in)
        reset_request_out |=> reset_request_out [*3];
    endproperty
    a_hold: assert property (p_hold) else $error("Reset request dropped");
endmodule
`default_nettype wire

// [bench/wwdt_cpu_model.sv]
// Behavioural model of the core that issues watchdog instructions
`timescale 1ns/1ps
`default_nettype none
module wwdt_cpu_model (
    input  wire logic clock_in,
    output logic      service_out,
    output logic      disable_out,
    output logic      enable_out
);
    initial begin
        service_out = 1'b0;
        disable_out = 1'b0;
        enable_out  = 1'b0;
    end

    // ---------------------------------------------
    // One-cycle instruction pulse: 0 service, 1 stop, 2 start
    // ---------------------------------------------
    task automatic issue(input int kind);
        @(posedge clock_in);
        service_out <= (kind == 0);
        disable_out <= (kind == 1);
        enable_out  <= (kind == 2);
        @(posedge clock_in);
        service_out <= 1'b0;
        disable_out <= 1'b0;
        enable_out  <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking testbench of the window watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb import wwdt_pkg::*; ;
    logic              clock_in;
    logic              rst_in;
    logic              wake_clk;
    logic              svc;
    logic              dis;
    logic              ena;
    wwdt_bus_t         bus;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] got;
    logic              req;
    logic              run;
    logic [CNT_W-1:0]  rl;
    int                n_mismatch;
    int                comparisons;
    int                m_cnt;
    logic              m_run;
    logic              m_req;
    logic              m_win;

    wwdt_top u_wwdt_top (
        .clock_in                        (clock_in),
        .rst_in                          (rst_in),
        .bus_in                          (bus),
        .wakeup_osc_clock_in             (wake_clk),
        .watchdog_service_in             (svc),
        .watchdog_disable_instruction_in (dis),
        .watchdog_enable_instruction_in  (ena),
        .rd_data_out                     (rd_data),
        .reset_request_out               (req),
        .running_out                     (run)
    );

    wwdt_cpu_model u_wwdt_cpu_model (
        .clock_in    (clock_in),
        .service_out (svc),
        .disable_out (dis),
        .enable_out  (ena)
    );

    // ---------------------------------------------
    // Clocks: system 100 MHz, wake-up 25 MHz
    // ---------------------------------------------
    initial clock_in = 1'b0;
    always #5 clock_in = ~clock_in;
    initial wake_clk = 1'b0;
    always #20 wake_clk = ~wake_clk;

    // ---------------------------------------------
    // Bus tasks and model
    // ---------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clock_in);
        bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_in);
        bus.rd <= 1'b0;
        #1 got = rd_data;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    task automatic do_reset;
        @(posedge clock_in);
        rst_in <= 1'b1;
        idle(20);
        rst_in <= 1'b0;
        m_cnt = RELOAD_RST;
        m_run = 1'b1;
        m_req = 1'b0;
        m_win = 1'b0;
    endtask

    function automatic logic [DATA_W-1:0] exp_stat();
        return {13'h0, m_win, m_req, m_run, m_cnt[15:0]};
    endfunction

    task automatic print_verdict;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ---------------------------------------------
    // Watchdog of the run
    // ---------------------------------------------
    initial begin
        #500000;
        n_mismatch++;
        print_verdict();
    end

    // ---------------------------------------------
    // Tests
    // ---------------------------------------------
    initial begin
        rst_in = 1'b1;
        bus = '0;
        n_mismatch = 0;
        comparisons = 0;
        void'($urandom(53068));
        do_reset();
        rd(OFS_CTRL);
        `CHK("ctrl", {30'h0, CTRL_LONG_RST, CTRL_WAKEUP_RST}, got)
        rd(OFS_RELOAD);
        `CHK("reload", {16'h0, RELOAD_RST}, got)
        rd(OFS_WINDOW);
        `CHK("window", {16'h0, WINDOW_RST}, got)
        rd(4'h2);
        `CHK("unmapped", 32'h0, got)
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        `CHK("running", 1'b1, run)
        // Reload and count on system clock, divide by 256
        wr(OFS_CTRL, 32'h0);
        rl = 16'hfff0 + 16'($urandom_range(7));
        wr(OFS_RELOAD, {16'h0, rl});
        u_wwdt_cpu_model.issue(0);
        m_cnt = rl;
        idle(100);
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        for (int k = 0; k < 3; k++) begin
            idle(254);
            m_cnt++;
            rd(OFS_STATUS);
            `CHK("status", exp_stat(), got)
        end
        // Stop, service while stopped, start
        u_wwdt_cpu_model.issue(1);
        m_run = 1'b0;
        idle(2);
        `CHK("running", 1'b0, run)
        idle(600);
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        u_wwdt_cpu_model.issue(0);
        m_cnt = rl;
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        u_wwdt_cpu_model.issue(2);
        m_run = 1'b1;
        idle(2);
        `CHK("running", 1'b1, run)
        // Overflow and sticky request
        wr(OFS_RELOAD, 32'hfffe);
        u_wwdt_cpu_model.issue(0);
        idle(400);
        `CHK("request", 1'b0, req)
        idle(300);
        `CHK("request", 1'b1, req)
        u_wwdt_cpu_model.issue(0);
        u_wwdt_cpu_model.issue(2);
        idle(300);
        `CHK("request", 1'b1, req)
        m_cnt = 0;
        m_run = 1'b0;
        m_req = 1'b1;
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        // Window boundary, random bound above the reload value
        do_reset();
        wr(OFS_CTRL, 32'h0);
        wr(OFS_WINDOW, {16'h0, 16'h0100 + 16'($urandom_range(16'h7f00))});
        wr(OFS_RELOAD, 32'h0010);
        u_wwdt_cpu_model.issue(0);
        m_cnt = 16'h0010;
        idle(2);
        `CHK("request", 1'b0, req)
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        u_wwdt_cpu_model.issue(0);
        m_run = 1'b0;
        m_req = 1'b1;
        m_win = 1'b1;
        idle(2);
        `CHK("request", 1'b1, req)
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        // Wake-up clock source
        do_reset();
        wr(OFS_CTRL, 32'h1);
        rl = 16'h0100 + 16'($urandom_range(255));
        wr(OFS_RELOAD, {16'h0, rl});
        u_wwdt_cpu_model.issue(0);
        m_cnt = rl;
        idle(600);
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        idle(600);
        m_cnt++;
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        // Long divider on system clock
        wr(OFS_CTRL, 32'h2);
        wr(OFS_RELOAD, 32'h0200);
        u_wwdt_cpu_model.issue(0);
        m_cnt = 16'h0200;
        idle(1000);
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        idle(15500);
        m_cnt++;
        rd(OFS_STATUS);
        `CHK("status", exp_stat(), got)
        print_verdict();
    end
endmodule
`default_nettype wire
